// ---- tuner_cfg_map.vh ----
// Register map, field positions, reset values and audio levels for the tuner config bank
`ifndef TUNER_CFG_MAP_VH
`define TUNER_CFG_MAP_VH
// ==========================================
// Register indices and byte addresses
`define IDX_SOFTMUTE_SEEK_CONFIG 4'h6
`define IDX_OSCILLATOR_AUDIO_TEST 4'h7
`define IDX_RESERVED_TEST_WORD 4'h8
`define IDX_BOOT_SETTINGS 4'h9
`define IDX_VOLUME_CTRL 4'hA
`define IDX_POWER_STATUS 4'hB
`define ADDR_LSB 2
`define ADDR_W 12
// ==========================================
// Reset values
`define RST_SOFTMUTE_SEEK_CONFIG 16'h0000
`define RST_OSCILLATOR_AUDIO_TEST 16'h0100
`define RST_RESERVED_TEST_WORD 16'h0000
`define RST_BOOT_SETTINGS 16'h0000
`define RST_VOLUME_CTRL 16'h0000
// ==========================================
// Field positions
`define F_SOFTMUTE_RATE_HI 15
`define F_SOFTMUTE_RATE_LO 14
`define F_SOFTMUTE_ATTEN_HI 13
`define F_SOFTMUTE_ATTEN_LO 12
`define F_RSVD_CFG3_HI 11
`define F_RSVD_CFG3_LO 9
`define F_EXTENDED_VOLUME_RANGE 8
`define F_SEEK_SNR_HI 7
`define F_SEEK_SNR_LO 4
`define F_SEEK_IMPULSE_HI 3
`define F_SEEK_IMPULSE_LO 0
`define F_CRYSTAL_OSC_ENABLE 15
`define F_AUDIO_HIGH_Z_ENABLE 14
`define F_VOLUME_HI 3
`define F_VOLUME_LO 0
// ==========================================
// Audio levels in dB of attenuation, and the low bits of the test word for power down and power up
`define ATTEN_SOFTMUTE_BASE_DB 8'h10
`define ATTEN_SOFTMUTE_STEP_DB 8'h02
`define ATTEN_EXTENDED_VOLUME_RANGE_DB 8'h1E
`define ATTEN_VOL_STEP_DB 8'h02
`define ATTEN_MUTE_DB 8'hFF
`define TEST1_LOW_POWERDOWN 14'h0100
`define TEST1_LOW_POWERUP 14'h3C04
`endif

// ---- pin_sync.v ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module pin_sync #(
  parameter W = 1
) (
  input wire pclk,
  input wire presetn,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  genvar i;
  // ==========================================
  // Sync chain; s1_r is read only by s2_r
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
      s3_r <= {W{1'b0}};
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  // Per bit, a change counts once stages two and three agree
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          q[i] <= 1'b0;
        end else if (s2_r[i] == s3_r[i]) begin
          q[i] <= s3_r[i];
        end
      end
    end
  endgenerate
endmodule // pin_sync

// ---- tuner_cfg_regs.v ----
// APB register bank for softmute, seek, oscillator, audio and test settings
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ns
`include "tuner_cfg_map.vh"
// How it works
// - The softmute rate field in bits 15:14 of the config word picks speed, 0 fastest, 3 slowest, reset fastest.
// - The softmute attenuation field gives 16, 14, 12 or 10 dB for codes 0 to 3, reset 16 dB.
// - The extended volume bit adds 30 dB of attenuation so volume spans -30 to -58 dBFS, reset off.
// - The four-bit SNR threshold sets the seek stop SNR; zero disables, 1 least strict, 15 strictest.
// - The four-bit impulse threshold sets allowed impulses; zero disables, 1 most stops, 15 fewest.
// - The audio high-Z bit holds both audio outputs at mid bias, only while powered down with IO supply.
// - The oscillator/audio test word resets to 0x0100, the other four words to 0x0000.
// - The volume field mutes at 0 and is full level at 15, shifted down by the extended range bit.
module tuner_cfg_regs (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire powered_up,
  input wire powerup_busy,
  input wire io_supply_ok,
  output reg [1:0] softmute_rate,
  output reg [7:0] softmute_atten_db,
  output reg [7:0] volume_atten_db,
  output reg extended_volume_range,
  output reg [3:0] seek_snr_threshold,
  output reg seek_snr_check_en,
  output reg [3:0] seek_impulse_threshold,
  output reg seek_impulse_check_en,
  output reg crystal_osc_enable,
  output reg audio_high_z_enable,
  output reg left_audio_out_hold,
  output reg right_audio_out_hold,
  output reg [15:0] reserved_test_word,
  output reg [15:0] boot_settings
);
  // ==========================================
  // Register storage
  reg [15:0] softmute_seek_config_r;
  reg [15:0] oscillator_audio_test_r;
  reg [15:0] reserved_test_word_r;
  reg [15:0] boot_settings_r;
  reg [15:0] volume_ctrl_r;
  reg [31:0] rdata_nxt;
  reg hit_nxt;
  wire [2:0] pins_q;
  wire pwr_up_s;
  wire pwr_busy_s;
  wire io_ok_s;
  wire [3:0] idx;
  wire idx_aligned;
  wire acc;
  wire wr;
  wire [15:0] wmask;
  wire [15:0] wdat;
  wire [1:0] atten_code;
  wire [3:0] vol_code;
  wire [7:0] vol_base_db;
  // ==========================================
  // Power state pins come from another domain
  pin_sync #(
    .W(3)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({io_supply_ok, powerup_busy, powered_up}),
    .q(pins_q)
  );
  assign pwr_up_s = pins_q[0];
  assign pwr_busy_s = pins_q[1];
  assign io_ok_s = pins_q[2];
  // ==========================================
  // APB decode; one-word aligned registers, zero-wait answer
  assign idx = paddr[`ADDR_LSB+3:`ADDR_LSB];
  assign idx_aligned = (paddr[`ADDR_W-1:`ADDR_LSB+4] == {(`ADDR_W-`ADDR_LSB-4){1'b0}}) &&
                       (paddr[`ADDR_LSB-1:0] == 2'b00);
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite && hit_nxt;
  assign wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  assign wdat = pwdata[15:0];
  always @* begin
    rdata_nxt = 32'h00000000;
    hit_nxt = idx_aligned;
    case (idx)
      `IDX_SOFTMUTE_SEEK_CONFIG: begin
        rdata_nxt = {16'h0000, softmute_seek_config_r};
      end
      `IDX_OSCILLATOR_AUDIO_TEST: begin
        rdata_nxt = {16'h0000, oscillator_audio_test_r};
      end
      `IDX_RESERVED_TEST_WORD: begin
        rdata_nxt = {16'h0000, reserved_test_word_r};
      end
      `IDX_BOOT_SETTINGS: begin
        rdata_nxt = {16'h0000, boot_settings_r};
      end
      `IDX_VOLUME_CTRL: begin
        rdata_nxt = {16'h0000, volume_ctrl_r};
      end
      `IDX_POWER_STATUS: begin
        rdata_nxt = {29'h00000000, io_ok_s, pwr_busy_s, pwr_up_s};
      end
      default: begin
        hit_nxt = 1'b0;
      end
    endcase
    if (!idx_aligned) begin
      rdata_nxt = 32'h00000000;
    end
  end
  // ==========================================
  // Bus answer; pready low in reset, then high from the first clock after it, so every access phase completes in one cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (psel && !penable) begin
        prdata <= pwrite ? 32'h00000000 : rdata_nxt;
        pslverr <= !hit_nxt;
      end
    end
  end
  // ==========================================
  // Register writes; reserved bits are stored as written so read-modify-write works
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      softmute_seek_config_r <= `RST_SOFTMUTE_SEEK_CONFIG;
      oscillator_audio_test_r <= `RST_OSCILLATOR_AUDIO_TEST;
      reserved_test_word_r <= `RST_RESERVED_TEST_WORD;
      boot_settings_r <= `RST_BOOT_SETTINGS;
      volume_ctrl_r <= `RST_VOLUME_CTRL;
    end else if (wr) begin
      case (idx)
        `IDX_SOFTMUTE_SEEK_CONFIG: begin
          // Bits 11:9 kept as written; software owes zeros there
          softmute_seek_config_r <= (softmute_seek_config_r & ~wmask) | (wdat & wmask);
        end
        `IDX_OSCILLATOR_AUDIO_TEST: begin
          // Low bits are whatever software supplies; no forcing, to keep readback honest
          oscillator_audio_test_r <= (oscillator_audio_test_r & ~wmask) | (wdat & wmask);
        end
        `IDX_RESERVED_TEST_WORD: begin
          reserved_test_word_r <= (reserved_test_word_r & ~wmask) | (wdat & wmask);
        end
        `IDX_BOOT_SETTINGS: begin
          boot_settings_r <= (boot_settings_r & ~wmask) | (wdat & wmask);
        end
        `IDX_VOLUME_CTRL: begin
          volume_ctrl_r <= (volume_ctrl_r & ~wmask) | (wdat & wmask);
        end
        default: begin
          volume_ctrl_r <= volume_ctrl_r;
        end
      endcase
    end
  end
  // ==========================================
  // Decoded controls, all registered
  assign atten_code = softmute_seek_config_r[`F_SOFTMUTE_ATTEN_HI:`F_SOFTMUTE_ATTEN_LO];
  assign vol_code = volume_ctrl_r[`F_VOLUME_HI:`F_VOLUME_LO];
  // Attenuation below full scale: code 15 is 0 dB, each step down adds 2 dB
  assign vol_base_db = {3'b000, ~vol_code, 1'b0};
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      softmute_rate <= 2'b00;
      softmute_atten_db <= `ATTEN_SOFTMUTE_BASE_DB;
      volume_atten_db <= `ATTEN_MUTE_DB;
      extended_volume_range <= 1'b0;
      seek_snr_threshold <= 4'h0;
      seek_snr_check_en <= 1'b0;
      seek_impulse_threshold <= 4'h0;
      seek_impulse_check_en <= 1'b0;
      crystal_osc_enable <= 1'b0;
      audio_high_z_enable <= 1'b0;
      left_audio_out_hold <= 1'b0;
      right_audio_out_hold <= 1'b0;
      reserved_test_word <= 16'h0000;
      boot_settings <= 16'h0000;
    end else begin
      // 0 fastest through 3 slowest
      softmute_rate <= softmute_seek_config_r[`F_SOFTMUTE_RATE_HI:`F_SOFTMUTE_RATE_LO];
      softmute_atten_db <= `ATTEN_SOFTMUTE_BASE_DB -
                           ({6'h00, atten_code} * `ATTEN_SOFTMUTE_STEP_DB);
      extended_volume_range <= softmute_seek_config_r[`F_EXTENDED_VOLUME_RANGE];
      if (vol_code == 4'h0) begin
        volume_atten_db <= `ATTEN_MUTE_DB;
      end else if (softmute_seek_config_r[`F_EXTENDED_VOLUME_RANGE]) begin
        volume_atten_db <= vol_base_db + `ATTEN_EXTENDED_VOLUME_RANGE_DB;
      end else begin
        volume_atten_db <= vol_base_db;
      end
      // Higher SNR code demands more SNR, zero turns the check off
      seek_snr_threshold <= softmute_seek_config_r[`F_SEEK_SNR_HI:`F_SEEK_SNR_LO];
      seek_snr_check_en <= |softmute_seek_config_r[`F_SEEK_SNR_HI:`F_SEEK_SNR_LO];
      seek_impulse_threshold <= softmute_seek_config_r[`F_SEEK_IMPULSE_HI:`F_SEEK_IMPULSE_LO];
      seek_impulse_check_en <= |softmute_seek_config_r[`F_SEEK_IMPULSE_HI:`F_SEEK_IMPULSE_LO];
      // Oscillator follows the bit directly; sequencing is software's job
      crystal_osc_enable <= oscillator_audio_test_r[`F_CRYSTAL_OSC_ENABLE];
      audio_high_z_enable <= oscillator_audio_test_r[`F_AUDIO_HIGH_Z_ENABLE];
      // Bias hold only while powered down with IO supply present
      left_audio_out_hold <= oscillator_audio_test_r[`F_AUDIO_HIGH_Z_ENABLE] &&
                             !pwr_up_s && !pwr_busy_s && io_ok_s;
      right_audio_out_hold <= oscillator_audio_test_r[`F_AUDIO_HIGH_Z_ENABLE] &&
                              !pwr_up_s && !pwr_busy_s && io_ok_s;
      reserved_test_word <= reserved_test_word_r;
      boot_settings <= boot_settings_r;
    end
  end
endmodule // tuner_cfg_regs

// ---- tuner_cfg_regs_assertions.sv ----
// Concurrent checks on the ports of the tuner config bank
`timescale 1ns/1ns
`include "tuner_cfg_map.vh"
module tuner_cfg_regs_checker (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire powered_up,
  input wire [1:0] softmute_rate,
  input wire [7:0] softmute_atten_db,
  input wire extended_volume_range,
  input wire [3:0] seek_snr_threshold,
  input wire seek_snr_check_en,
  input wire [3:0] seek_impulse_threshold,
  input wire seek_impulse_check_en,
  input wire crystal_osc_enable,
  input wire audio_high_z_enable,
  input wire left_audio_out_hold,
  input wire right_audio_out_hold
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================
  // Config full-word and test-word upper-byte write steps; fields show two edges after the access edge
  sequence cfg_wr;
    psel && penable && pready && pwrite && paddr == 12'h018 && pstrb[1:0] == 2'h3;
  endsequence
  sequence t1_wr;
    psel && penable && pready && pwrite && paddr == 12'h01C && pstrb[1];
  endsequence
  rate_follows_a: assert property (cfg_wr |=> ##1 softmute_rate == $past(pwdata[15:14], 2))
    else $error("softmute rate not taken from write");
  atten_code_a: assert property (cfg_wr |=> ##1
    softmute_atten_db == 8'h10 - {5'h00, $past(pwdata[13:12], 2), 1'b0})
    else $error("softmute attenuation wrong");
  ext_volume_a: assert property (cfg_wr |=> ##1 extended_volume_range == $past(pwdata[8], 2))
    else $error("extended volume bit not taken");
  snr_thresh_a: assert property (cfg_wr |=> ##1 seek_snr_threshold == $past(pwdata[7:4], 2)
    && seek_snr_check_en == (seek_snr_threshold != 4'h0))
    else $error("snr threshold or enable wrong");
  impulse_thresh_a: assert property (cfg_wr |=> ##1
    seek_impulse_threshold == $past(pwdata[3:0], 2)
    && seek_impulse_check_en == (seek_impulse_threshold != 4'h0))
    else $error("impulse threshold or enable wrong");
  osc_follows_a: assert property (t1_wr |=> ##1 crystal_osc_enable == $past(pwdata[15], 2))
    else $error("oscillator enable not taken");
  hiz_needs_en_a: assert property (left_audio_out_hold |-> audio_high_z_enable
    && right_audio_out_hold)
    else $error("audio hold without enable or unpaired");
  hiz_up_off_a: assert property (powered_up [*7] |-> !left_audio_out_hold)
    else $error("audio hold while powered up");
  unmapped_err_a: assert property (psel && !penable && paddr == 12'h030
    |=> pslverr && prdata == 32'h00000000)
    else $error("unmapped access not refused");
endmodule // tuner_cfg_regs_checker
bind tuner_cfg_regs tuner_cfg_regs_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .powered_up(powered_up),
  .softmute_rate(softmute_rate), .softmute_atten_db(softmute_atten_db),
  .extended_volume_range(extended_volume_range), .seek_snr_threshold(seek_snr_threshold),
  .seek_snr_check_en(seek_snr_check_en), .seek_impulse_threshold(seek_impulse_threshold),
  .seek_impulse_check_en(seek_impulse_check_en), .crystal_osc_enable(crystal_osc_enable),
  .audio_high_z_enable(audio_high_z_enable), .left_audio_out_hold(left_audio_out_hold),
  .right_audio_out_hold(right_audio_out_hold));

// ---- fm_tuner_config_test_regs_tb_top.sv ----
// Self-checking bench for the tuner config bank
`timescale 1ns/1ns
`include "tuner_cfg_map.vh"
module fm_tuner_config_test_regs_tb_top;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h00000000;
  reg [3:0] pstrb = 4'hF;
  reg powered_up = 1'b0;
  reg powerup_busy = 1'b0;
  reg io_supply_ok = 1'b1;
  wire [31:0] prdata;
  wire pready, pslverr, extended_volume_range, seek_snr_check_en, seek_impulse_check_en;
  wire crystal_osc_enable, audio_high_z_enable, left_audio_out_hold, right_audio_out_hold;
  wire [1:0] softmute_rate;
  wire [7:0] softmute_atten_db, volume_atten_db;
  wire [3:0] seek_snr_threshold, seek_impulse_threshold;
  wire [15:0] reserved_test_word, boot_settings;
  integer bad_count = 0;
  integer n_compared = 0;
  integer i, k;
  reg [31:0] seed = 32'h00000012;
  reg [31:0] rd;
  reg er;
  reg [15:0] m [0:15];
  always #2 pclk = ~pclk;
  tuner_cfg_regs i_tuner_cfg_regs (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .powered_up(powered_up),
    .powerup_busy(powerup_busy), .io_supply_ok(io_supply_ok), .softmute_rate(softmute_rate),
    .softmute_atten_db(softmute_atten_db), .volume_atten_db(volume_atten_db),
    .extended_volume_range(extended_volume_range), .seek_snr_threshold(seek_snr_threshold),
    .seek_snr_check_en(seek_snr_check_en), .seek_impulse_threshold(seek_impulse_threshold),
    .seek_impulse_check_en(seek_impulse_check_en), .crystal_osc_enable(crystal_osc_enable),
    .audio_high_z_enable(audio_high_z_enable), .left_audio_out_hold(left_audio_out_hold),
    .right_audio_out_hold(right_audio_out_hold), .reserved_test_word(reserved_test_word),
    .boot_settings(boot_settings));
  // ==========================================
  // Helpers
  function [31:0] xs(input [31:0] s);
    reg [31:0] x;
    begin
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
    end
  endfunction
  task check(input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task test_done;
    begin
      $display("Compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  // Master never assumes zero wait states; only the watchdog ends a hung access
  task apb(input w, input [11:0] a, input [31:0] d, input [3:0] s);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
        @(posedge pclk);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wr(input [3:0] x, input [15:0] d, input [3:0] s);
    begin
      apb(1'b1, {6'h00, x, 2'b00}, {16'h0000, d}, s);
      if (x >= 4'h6 && x <= 4'hA) begin
        if (s[0]) m[x][7:0] = d[7:0];
        if (s[1]) m[x][15:8] = d[15:8];
      end
    end
  endtask
  task rd_chk(input [3:0] x);
    begin
      apb(1'b0, {6'h00, x, 2'b00}, 32'h00000000, 4'h0);
      check(rd, {16'h0000, m[x]});
    end
  endtask
  task do_reset;
    begin
      presetn <= 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      m[6] = 16'h0000;
      m[7] = 16'h0100;
      m[8] = 16'h0000;
      m[9] = 16'h0000;
      m[10] = 16'h0000;
      @(posedge pclk);
      for (k = 6; k < 10; k = k + 1) rd_chk(k[3:0]);
    end
  endtask
  task out_chk;
    reg [15:0] g;
    reg [7:0] v;
    reg h;
    begin
      g = m[6];
      v = {3'h0, 4'hF - m[10][3:0], 1'b0} + (g[8] ? 8'h1E : 8'h00);
      h = m[7][14] & !powered_up & !powerup_busy & io_supply_ok;
      check(softmute_rate, g[15:14]);
      check(softmute_atten_db, 8'h10 - {5'h00, g[13:12], 1'b0});
      check(extended_volume_range, g[8]);
      check(volume_atten_db, (m[10][3:0] == 4'h0) ? 8'hFF : v);
      check({seek_snr_check_en, seek_snr_threshold}, {|g[7:4], g[7:4]});
      check({seek_impulse_check_en, seek_impulse_threshold}, {|g[3:0], g[3:0]});
      check(crystal_osc_enable, m[7][15]);
      check({left_audio_out_hold, right_audio_out_hold, audio_high_z_enable}, {h, h, m[7][14]});
      check({reserved_test_word, boot_settings}, {m[8], m[9]});
    end
  endtask
  // ==========================================
  // Main sequence
  initial begin
    do_reset;
    for (i = 0; i < 16; i = i + 1) begin
      seed = xs(seed);
      @(posedge pclk);
      powered_up <= seed[0];
      powerup_busy <= seed[1] & seed[2];
      io_supply_ok <= seed[3];
      wr(4'h6, {i[1:0], i[3:2], 3'b000, seed[4], 1'b0, i[2:0], i[3:0]}, 4'hF);
      wr(4'hA, {12'h000, seed[11:8]}, 4'hF);
      if (!(seed[1] & seed[2])) begin
        wr(4'h7, {seed[0] | seed[12], seed[13], seed[0] ? 14'h3C04 : 14'h0100}, 4'hF);
        wr(4'h8, seed[31:16], 4'hF);
        wr(4'h9, seed[27:12], {2'b00, seed[5], seed[6]});
        rd_chk(4'h8);
        wr(4'h8, rd[15:0], 4'hF);
      end
      repeat (8) @(posedge pclk);
      out_chk;
      apb(1'b0, 12'h02C, 32'h00000000, 4'h0);
      check(rd, {29'h0000000, io_supply_ok, powerup_busy, powered_up});
      for (k = 6; k < 11; k = k + 1) rd_chk(k[3:0]);
    end
    wr(4'hC, 16'hFFFF, 4'hF);
    check(er, 1'b1);
    apb(1'b0, 12'h030, 32'h00000000, 4'h0);
    check(rd, 32'h00000000);
    check(er, 1'b1);
    apb(1'b0, 12'h019, 32'h00000000, 4'h0);
    check(er, 1'b1);
    rd_chk(4'h6);
    do_reset;
    out_chk;
    test_done;
  end
  // Whole run is under a thousand cycles; this span only trips on a hang
  initial begin
    #100000;
    bad_count = bad_count + 1;
    test_done;
  end
endmodule // fm_tuner_config_test_regs_tb_top
